// ==== icss_regs.vh ====
/*
 Constants for the initiator command step sequencer: command codes,
 step codes, bus phase codes and field positions.
 Assumes inclusion by icss_sequencer.v and by the testbench.
*/
`ifndef ICSS_REGS_VH
`define ICSS_REGS_VH
`define ICSS_CMD_SEL_1MSG_CMD   5'h02
`define ICSS_CMD_SEL_1MSG       5'h04
`define ICSS_CMD_SEND_NMSG      5'h06
`define ICSS_CMD_SEND_NCMD      5'h07
`define ICSS_CMD_RECV_NMSG      5'h08
`define ICSS_CMD_SEND_MPU       5'h0F
`define ICSS_CMD_SEND_DMA       5'h10
`define ICSS_CMD_RECV_MPU       5'h11
`define ICSS_CMD_RECV_DMA       5'h12
`define ICSS_CMD_SEND_MPU_PAD   5'h13
`define ICSS_CMD_SEND_DMA_PAD   5'h14
`define ICSS_CMD_RECV_MPU_PAD   5'h15
`define ICSS_CMD_RECV_DMA_PAD   5'h16
`define ICSS_CMD_SEND_1MSG      5'h17
`define ICSS_CMD_SEND_1MSG_ATN  5'h18
`define ICSS_CMD_RECV_MSG       5'h19
`define ICSS_CMD_SEND_CMD       5'h1A
`define ICSS_CMD_RECV_STATUS    5'h1B
`define ICSS_PH_DATA_OUT        3'h0
`define ICSS_PH_DATA_IN         3'h1
`define ICSS_PH_CMD             3'h2
`define ICSS_PH_STATUS          3'h3
`define ICSS_PH_MSG_OUT         3'h6
`define ICSS_PH_MSG_IN          3'h7
`define ICSS_STEP_0             3'h0
`define ICSS_STEP_1             3'h1
`define ICSS_STEP_2             3'h2
`define ICSS_STEP_3             3'h3
`define ICSS_STEP_4             3'h4
`define ICSS_STEP_5             3'h5
`define ICSS_MISALIGN_BIT       7
`define ICSS_BLOCK_LEN          8'h08
`endif

// ==== icss_sequencer.v ====
/*
 Initiator command sequencer: runs selecting and single-phase commands,
 reports the step code, moves bytes with REQ/ACK and DMA in blocks gated by
 transfer permission. Assumes the bus-side arbitration/selection results and
 the phase lines come in as pins; byte data paths live elsewhere.
*/
`timescale 1ns/1ps
`include "icss_regs.vh"
// How it works
// - Step 0 awaiting bus free, 1 arbitrating
// - Step 2 selecting; timeout ends it, lost arbitration ends at step 1
// - Select-msg-cmd: steps 3, 4, 5
// - Select-msg only ends at step 4
// - Single-phase: step 0, 1, then 2
// - Each command waits its matching phase
// - Data send waits DATA OUT
// - Data receive waits DATA IN
// - DMA moves blocks, permission checked per block
// - Initiator pause: REQ left unanswered, ACK held low, no DMA request
// - Paused DATA IN bytes equal REQs answered with ACK
// - Target pause: no REQ, DMA request low
// - Bit 7 allows odd-address DMA
module icss_sequencer
(
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_cmd_valid,
  input  wire [4:0] i_cmd_code,
  input  wire [7:0] i_byte_count,
  input  wire       i_target_mode,
  input  wire [7:0] i_select_reselect_identity,
  input  wire       i_bus_free,
  input  wire       i_arb_won,
  input  wire       i_arb_lost,
  input  wire       i_sel_done,
  input  wire       i_sel_timeout,
  input  wire [2:0] i_phase,
  input  wire       i_req,
  input  wire       i_ack,
  input  wire       i_transfer_permission,
  input  wire       i_dma_ack,
  output wire       o_cmd_ready,
  output reg  [2:0] o_step,
  output reg        o_busy,
  output reg        o_done,
  output reg        o_fail,
  output reg        o_ack_out,
  output reg        o_req_out,
  output wire       o_dma_request_out,
  output reg        o_paused,
  output reg        o_odd_dma_enable,
  output reg  [7:0] o_bytes_moved
);
  localparam ST_IDLE  = 6'h01;
  localparam ST_FREE  = 6'h02;
  localparam ST_ARB   = 6'h04;
  localparam ST_SEL   = 6'h08;
  localparam ST_PHASE = 6'h10;
  localparam ST_XFER  = 6'h20;

  reg [5:0] state_q;
  reg [2:0] cmd_q;
  reg [4:0] code_q;
  reg [7:0] count_q;
  reg [7:0] left_q;
  reg [7:0] blk_q;
  reg       perm_q;
  reg [2:0] meta_q;
  reg [2:0] sync_q;
  reg [2:0] want_ph;
  reg       is_dma;
  reg       is_sel;
  reg       sel_cmd;

  wire perm = sync_q[0];
  wire req  = sync_q[1];
  wire ack  = sync_q[2];
  wire phase_ok = (i_phase == want_ph);
  wire blk_end  = (blk_q == `ICSS_BLOCK_LEN - 8'h01);

  assign o_cmd_ready = state_q[0];
  assign o_dma_request_out = state_q[5] & is_dma & ~o_paused & perm;

  always @*
  begin
    is_dma  = 1'b0;
    is_sel  = 1'b0;
    sel_cmd = 1'b0;
    want_ph = `ICSS_PH_MSG_OUT;
    case (code_q)
      `ICSS_CMD_SEL_1MSG_CMD:
      begin
        is_sel  = 1'b1;
        sel_cmd = 1'b1;
      end
      `ICSS_CMD_SEL_1MSG:      is_sel = 1'b1;
      `ICSS_CMD_SEND_NCMD, `ICSS_CMD_SEND_CMD: want_ph = `ICSS_PH_CMD;
      `ICSS_CMD_RECV_NMSG, `ICSS_CMD_RECV_MSG: want_ph = `ICSS_PH_MSG_IN;
      `ICSS_CMD_RECV_STATUS:   want_ph = `ICSS_PH_STATUS;
      `ICSS_CMD_SEND_MPU, `ICSS_CMD_SEND_MPU_PAD: want_ph = `ICSS_PH_DATA_OUT;
      `ICSS_CMD_SEND_DMA, `ICSS_CMD_SEND_DMA_PAD:
      begin
        want_ph = `ICSS_PH_DATA_OUT;
        is_dma  = 1'b1;
      end
      `ICSS_CMD_RECV_MPU, `ICSS_CMD_RECV_MPU_PAD: want_ph = `ICSS_PH_DATA_IN;
      `ICSS_CMD_RECV_DMA, `ICSS_CMD_RECV_DMA_PAD:
      begin
        want_ph = `ICSS_PH_DATA_IN;
        is_dma  = 1'b1;
      end
      default: want_ph = `ICSS_PH_MSG_OUT;
    endcase
    if (is_sel && cmd_q == `ICSS_STEP_4)
      want_ph = `ICSS_PH_CMD;
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_q   <= 3'h0;
      sync_q   <= 3'h0;
    end
    else
    begin
      meta_q   <= {i_ack, i_req, i_transfer_permission};
      sync_q   <= meta_q;
    end
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_q          <= ST_IDLE;
      cmd_q            <= `ICSS_STEP_0;
      code_q           <= 5'h00;
      count_q          <= 8'h00;
      left_q           <= 8'h00;
      blk_q            <= 8'h00;
      perm_q           <= 1'b1;
      o_step           <= `ICSS_STEP_0;
      o_busy           <= 1'b0;
      o_done           <= 1'b0;
      o_fail           <= 1'b0;
      o_ack_out        <= 1'b0;
      o_req_out        <= 1'b0;
      o_paused         <= 1'b0;
      o_odd_dma_enable <= 1'b0;
      o_bytes_moved    <= 8'h00;
    end
    else
    begin
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_req_out <= i_target_mode & state_q[5] & ~o_paused & ~ack;
      case (state_q)
        ST_IDLE:
        if (i_cmd_valid)
        begin
          code_q           <= i_cmd_code;
          count_q          <= i_byte_count;
          o_step           <= `ICSS_STEP_0;
          cmd_q            <= `ICSS_STEP_0;
          o_busy           <= 1'b1;
          o_bytes_moved    <= 8'h00;
          blk_q            <= 8'h00;
          perm_q           <= 1'b1;
          o_paused         <= 1'b0;
          o_odd_dma_enable <= i_select_reselect_identity[`ICSS_MISALIGN_BIT];
          state_q          <= (i_cmd_code == `ICSS_CMD_SEL_1MSG_CMD || i_cmd_code == `ICSS_CMD_SEL_1MSG) ?
                              ST_FREE : ST_PHASE;
        end
        ST_FREE:
        if (i_bus_free)
        begin
          o_step  <= `ICSS_STEP_1;
          state_q <= ST_ARB;
        end
        ST_ARB:
        if (i_arb_lost)
        begin
          o_fail  <= 1'b1;
          o_busy  <= 1'b0;
          state_q <= ST_IDLE;
        end
        else if (i_arb_won)
        begin
          o_step  <= `ICSS_STEP_2;
          state_q <= ST_SEL;
        end
        ST_SEL:
        if (i_sel_timeout)
        begin
          o_fail  <= 1'b1;
          o_busy  <= 1'b0;
          state_q <= ST_IDLE;
        end
        else if (i_sel_done)
        begin
          o_step  <= `ICSS_STEP_3;
          cmd_q   <= `ICSS_STEP_3;
          left_q  <= 8'h01;
          state_q <= ST_PHASE;
        end
        ST_PHASE:
        begin
          if (!is_sel)
            o_step <= `ICSS_STEP_1;
          if (phase_ok)
          begin
            if (!is_sel)
              left_q <= (count_q == 8'h00) ? 8'h01 : count_q;
            else if (cmd_q == `ICSS_STEP_4)
              left_q <= (count_q == 8'h00) ? 8'h01 : count_q;
            state_q <= ST_XFER;
          end
        end
        ST_XFER:
        begin
          if (o_paused && perm && blk_q == 8'h00)
            o_paused <= 1'b0;
          if (o_ack_out)
          begin
            if (!req)
            begin
              o_ack_out     <= 1'b0;
              o_bytes_moved <= o_bytes_moved + 8'h01;
              left_q        <= left_q - 8'h01;
              if (is_dma)
              begin
                blk_q <= blk_end ? 8'h00 : blk_q + 8'h01;
                if (!perm)
                  perm_q <= 1'b0;
                if (blk_end && (!perm || !perm_q))
                begin
                  o_paused  <= 1'b1;
                  o_req_out <= 1'b0;
                end
              end
              if (left_q == 8'h01)
              begin
                if (is_sel && sel_cmd && cmd_q == `ICSS_STEP_3)
                begin
                  o_step  <= `ICSS_STEP_4;
                  cmd_q   <= `ICSS_STEP_4;
                  state_q <= ST_PHASE;
                end
                else
                begin
                  if (!is_sel)
                    o_step <= `ICSS_STEP_2;
                  else if (sel_cmd)
                    o_step <= `ICSS_STEP_5;
                  else
                    o_step <= `ICSS_STEP_4;
                  o_done  <= 1'b1;
                  o_busy  <= 1'b0;
                  o_paused <= 1'b0;
                  o_req_out <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end
            end
          end
          // REQ taken by level so one raised early or during a pause is not lost
          else if (req && !o_paused && (!is_dma || i_dma_ack || perm))
          begin
            perm_q    <= perm;
            o_ack_out <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== icss_sequencer_assertions.sv ====
/* Port checker for icss_sequencer.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
module icss_checker
(
  input wire       i_clk,
  input wire       i_reset,
  input wire       o_cmd_ready,
  input wire [2:0] o_step,
  input wire       o_busy,
  input wire       o_done,
  input wire       o_fail,
  input wire       o_ack_out,
  input wire       o_dma_request_out,
  input wire       o_paused
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_done_fail_excl: assert property (o_done |-> !o_fail) else $error("done with fail");
  a_fail_step: assert property (o_fail |-> o_step inside {3'h1, 3'h2}) else $error("fail step");
  a_done_step: assert property (o_done |-> o_step inside {3'h2, 3'h4, 3'h5}) else $error("done step");
  a_done_ends: assert property (o_done |=> !o_done && !o_busy) else $error("done not ending");
  a_step_rises: assert property (o_busy && $past(o_busy) |-> o_step >= $past(o_step)) else $error("step fell");
  a_pause_dma_low: assert property (o_paused |-> !o_dma_request_out) else $error("dma req in pause");
  a_pause_no_ack: assert property (o_paused |-> !$rose(o_ack_out)) else $error("ack in pause");
  a_dma_in_data: assert property (o_dma_request_out |-> o_busy && o_step == 3'h1) else $error("dma req idle");
  a_ready_idle: assert property (o_busy |-> !o_cmd_ready) else $error("ready while busy");
  c_sel_done: cover property (o_done && o_step == 3'h5);
  c_fail: cover property (o_fail);
  c_resume: cover property ($fell(o_paused));
endmodule
bind icss_sequencer icss_checker u_chk (.*);

// ==== icss_target_model.sv ====
/* Bus target model: REQ/ACK byte handshake with a stall gap.
   Assumes ACK comes from the sequencer; REQ idles deasserted. */
`timescale 1ns/1ps
module icss_target_model
(
  input  wire       i_clk,
  input  wire       i_en,
  input  wire [1:0] i_gap,
  input  wire       i_ack,
  output reg        o_req
);
  initial
  begin
    o_req = 1'b0;
    forever
    begin
      @(posedge i_clk);
      if (i_en && !i_ack)
      begin
        repeat (i_gap) @(posedge i_clk);
        o_req <= 1'b1;
        while (!i_ack && i_en) @(posedge i_clk);
        o_req <= 1'b0;
        while (i_ack) @(posedge i_clk);
      end
    end
  end
endmodule

// ==== icss_sequencer_tb.sv ====
/* Testbench for icss_sequencer: table of single-phase commands, then
   selection, refusal of phase, and pause cases. Assumes icss_regs.vh.
*/
`timescale 1ns/1ps
`include "icss_regs.vh"
module icss_sequencer_tb;
  logic i_clk = 0, i_reset = 1, i_cmd_valid = 0, i_target_mode = 0, i_dma_ack = 1;
  logic i_bus_free = 0, i_arb_won = 0, i_arb_lost = 0, i_sel_done = 0, i_sel_timeout = 0;
  logic i_transfer_permission = 1, en = 0;
  logic [4:0] i_cmd_code = 5'h00;
  logic [7:0] i_byte_count = 8'h00, i_select_reselect_identity = 8'h00;
  logic [2:0] i_phase = 3'h0, ph4 = 3'h0;
  logic [1:0] gap = 2'h0;
  wire i_req, o_cmd_ready, o_busy, o_done, o_fail, o_ack_out, o_req_out, o_dma_request_out, o_paused;
  wire o_odd_dma_enable;
  wire [2:0] o_step;
  wire [7:0] o_bytes_moved;
  wire i_ack = o_ack_out;
  integer errors = 0, n_tests = 0, r;
  logic [4:0] cmd [0:15] = '{5'h06, 5'h07, 5'h08, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13,
                             5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B};
  logic [2:0] ph [0:15] = '{3'h6, 3'h2, 3'h7, 3'h0, 3'h0, 3'h1, 3'h1, 3'h0,
                            3'h0, 3'h1, 3'h1, 3'h6, 3'h6, 3'h7, 3'h2, 3'h3};
  icss_sequencer DUT (.*);
  icss_target_model u_tgt (.i_clk(i_clk), .i_en(en), .i_gap(gap), .i_ack(o_ack_out), .o_req(i_req));
  always #2.5 i_clk = ~i_clk;
  task check(input [7:0] seen, input [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task issue(input [4:0] c, input [7:0] n);
    @(negedge i_clk);
    i_cmd_code = c;
    i_byte_count = n;
    i_cmd_valid = 1'b1;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
  endtask
  task wait_end;
    integer k;
    for (k = 0; k < 3000 && o_done !== 1'b1 && o_fail !== 1'b1; k++)
    begin
      @(negedge i_clk);
      if (o_step === 3'h4) i_phase = ph4;
    end
    if (k == 3000) errors++;
  endtask
  task conclude;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    conclude;
  end
  initial
  begin
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    check({o_cmd_ready, 2'h0, o_step}, 8'h20, "reset");
    for (r = 0; r < 16; r++)
    begin
      i_phase = ph[r];
      ph4 = ph[r];
      gap = r[1:0];
      en = 1;
      issue(cmd[r], r + 1);
      wait_end;
      check({o_done, o_fail, o_busy, 2'h0, o_step}, 8'h82, "single");
      check(o_bytes_moved, r + 1, "bytes");
      en = 0;
      $display("row %0d finished", r);
    end
    issue(`ICSS_CMD_SEL_1MSG_CMD, 8'h03);
    repeat (4) @(negedge i_clk);
    check(o_step, 8'h00, "wait free");
    i_bus_free = 1;
    repeat (2) @(negedge i_clk);
    check(o_step, 8'h01, "arbitrate");
    i_arb_won = 1;
    repeat (2) @(negedge i_clk);
    check(o_step, 8'h02, "select");
    i_phase = `ICSS_PH_MSG_OUT;
    ph4 = `ICSS_PH_CMD;
    i_sel_done = 1;
    en = 1;
    wait_end;
    check({o_done, 4'h0, o_step}, 8'h85, "sel cmd");
    en = 0;
    i_phase = `ICSS_PH_MSG_OUT;
    ph4 = `ICSS_PH_MSG_OUT;
    issue(`ICSS_CMD_SEL_1MSG, 8'h01);
    en = 1;
    wait_end;
    check({o_done, 4'h0, o_step}, 8'h84, "sel msg");
    en = 0;
    i_sel_done = 0;
    for (r = 0; r < 2; r++)
    begin
      i_arb_won = r;
      i_sel_timeout = r;
      i_arb_lost = !r;
      issue(`ICSS_CMD_SEL_1MSG, 8'h01);
      wait_end;
      check({o_fail, 4'h0, o_step}, 8'h81 + r, "sel fail");
    end
    i_sel_timeout = 0;
    i_arb_lost = 0;
    $display("selection finished");
    i_phase = `ICSS_PH_DATA_OUT;
    en = 1;
    issue(`ICSS_CMD_RECV_STATUS, 8'h01);
    repeat (20) @(negedge i_clk);
    check({o_step, o_bytes_moved[4:0]}, 8'h20, "wrong phase");
    i_phase = `ICSS_PH_STATUS;
    wait_end;
    check(o_step, 8'h02, "status");
    en = 0;
    $display("phase wait finished");
    i_phase = `ICSS_PH_DATA_IN;
    i_select_reselect_identity = 8'h80;
    i_transfer_permission = 0;
    en = 1;
    issue(`ICSS_CMD_RECV_DMA, 8'h18);
    check(o_odd_dma_enable, 8'h01, "odd dma");
    for (r = 0; r < 500 && o_paused !== 1'b1; r++) @(negedge i_clk);
    repeat (10) @(negedge i_clk);
    check(o_bytes_moved, `ICSS_BLOCK_LEN, "block");
    check({o_paused, o_dma_request_out, o_ack_out, o_req_out}, 8'h08, "paused");
    i_transfer_permission = 1;
    wait_end;
    check(o_bytes_moved, 8'h18, "resume");
    en = 0;
    $display("pause finished");
    i_target_mode = 1;
    i_transfer_permission = 0;
    en = 1;
    issue(`ICSS_CMD_RECV_DMA, 8'h10);
    for (r = 0; r < 500 && o_paused !== 1'b1; r++) @(negedge i_clk);
    repeat (4) @(negedge i_clk);
    check({o_paused, o_req_out, o_dma_request_out}, 8'h04, "target pause");
    i_transfer_permission = 1;
    wait_end;
    check({o_done, 4'h0, o_step}, 8'h82, "target end");
    check(o_bytes_moved, 8'h10, "target bytes");
    en = 0;
    i_target_mode = 0;
    $display("target pause finished");
    conclude;
  end
endmodule
